// *** verilog/sgsc_pkg.sv ***
package sgsc_pkg;

    // ------------------------------------------------------------
    // Power states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        SGSC_RUN     = 5'h01,   // Normal execution
        SGSC_STPGNT  = 5'h02,   // Stop-Grant, bus and interrupt unit alive
        SGSC_SLEEP   = 5'h04,   // Sleep, only PLL alive
        SGSC_SMM_ENT = 5'h08,   // State saved, management ack pending
        SGSC_SMM     = 5'h10    // Running the management handler
    } sgsc_state_e;

    // ------------------------------------------------------------
    // Acknowledge transaction codes on the bus request port
    // ------------------------------------------------------------
    localparam logic [1:0] SGSC_ACK_NONE  = 2'h0;  // No transaction
    localparam logic [1:0] SGSC_ACK_STPGNT = 2'h1; // Stop-Grant acknowledge
    localparam logic [1:0] SGSC_ACK_SMI   = 2'h2;  // Management acknowledge

    // ------------------------------------------------------------
    // Synchroniser depth and reset values
    // ------------------------------------------------------------
    localparam int         SGSC_SYNC_STAGES = 2;     // Flops per async input
    localparam logic       SGSC_SYNC_RST    = 1'b1;  // Requests idle high

endpackage : sgsc_pkg

// *** verilog/sgsc_sync_if.sv ***
// ----------------------------------------------------------------
// Synchronised request bundle between synchroniser and controller
// ----------------------------------------------------------------
interface sgsc_sync_if;
    logic [2:0] raw_n;   // Async requests: {smi, stop, sleep}, active low
    logic [2:0] sync_n;  // Same after synchronisation

    modport src (input raw_n, output sync_n);
    modport dst (output raw_n, input sync_n);
endinterface : sgsc_sync_if

// *** verilog/sgsc_sync.sv ***
// ----------------------------------------------------------------
// Two-flop synchroniser bank for the asynchronous request pins
// ----------------------------------------------------------------
module sgsc_sync #(
    parameter int WIDTH = 3                   // Number of inputs
) (
    input  wire logic  clk_i,                 // Bus clock
    input  wire logic  arst_n_i,              // Async reset, active low
    sgsc_sync_if.src   sif                    // Raw in, synchronised out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;               // First stage, read by stage two only
        logic [WIDTH-1:0] sync;               // Second stage, safe to use
    } sgsc_sync_s;

    sgsc_sync_s s_q;                          // Registered state
    sgsc_sync_s s_d;                          // Next state

    // Shift raw pins through two flops
    always_comb begin
        s_d      = s_q;
        s_d.meta = sif.raw_n;
        s_d.sync = s_q.meta;
    end

    // Reset to idle (deasserted) so no false request on release
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= {(2 * WIDTH){sgsc_pkg::SGSC_SYNC_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign sif.sync_n = s_q.sync;

endmodule // sgsc_sync

// *** verilog/sgsc_ctrl.sv ***
// Contract
// (R1) Sleep request in Stop-Grant enters Sleep
// (R2) Sleep gates all clocks, PLL only
// (R3) Sleep ignores snoops and interrupts
// (R4) Sleep reacts only to sleep, stop, reset; the code leaves Sleep on sleep release or reset only and ignores stop
// (R5) Sleep release returns to Stop-Grant, bus clocks
// (R6) Stop request enters Stop-Grant, gates core
// (R7) Stop-Grant entry issues acknowledge transaction
// (R8) Stop-Grant keeps snooping and servicing interrupts
// (R9) Stop release restarts clocks, resumes execution
// (R10) Stop request async; bus clock untouched
// (R11) Management interrupt accepted asynchronously
// (R12) Management interrupt saves state, enters mode
// (R13) Management acknowledge then handler execution
// (R14) Synchronise inputs; ignore sleep outside Stop-Grant
module sgsc_ctrl (
    input  wire logic  clk_i,                       // Bus clock, 40 MHz
    input  wire logic  arst_n_i,                    // Async reset, active low
    input  wire logic  sleep_request_n_i,           // Async sleep request
    input  wire logic  stop_clock_request_n_i,      // Async stop-clock request
    input  wire logic  sys_mgmt_interrupt_n_i,      // Async management interrupt
    input  wire logic  snoop_req_i,                 // Bus snoop presented
    input  wire logic  intr_req_i,                  // Interrupt presented
    input  wire logic  smm_resume_i,                // Handler finished (resume)
    input  wire logic  ack_done_i,                  // Bus took acknowledge
    output logic       core_clk_en_o,               // Core units clock enable
    output logic       bus_clk_en_o,                // Bus unit clock enable
    output logic       lic_clk_en_o,                // Interrupt controller enable
    output logic       pll_en_o,                    // PLL keeps running
    output logic       snoop_en_o,                  // Snoops recognised
    output logic       intr_en_o,                   // Interrupts serviced
    output logic       exec_en_o,                   // Instruction execution
    output logic       state_save_o,                // One-cycle save strobe
    output logic       system_management_mode_o,    // In management mode
    output logic       handler_start_o,             // One-cycle handler launch
    output logic       ack_valid_o,                 // Ack transaction pending
    output logic [1:0] ack_type_o,                  // Ack transaction kind
    output logic       sleep_o                      // In Sleep
);

    // ------------------------------------------------------------
    // Request synchronisers
    // ------------------------------------------------------------
    sgsc_sync_if sif ();                            // Request bundle

    // Async pins go through two flops before use; R10, R11
    assign sif.raw_n = {sys_mgmt_interrupt_n_i, stop_clock_request_n_i, sleep_request_n_i};

    sgsc_sync #(
        .WIDTH   (3)
    ) u_sync (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .sif     (sif.src)
    ); // R14

    logic sleep_req;                                // Synchronised, active high
    logic stop_req;                                 // Synchronised, active high
    logic smi_req;                                  // Synchronised, active high

    assign sleep_req = ~sif.sync_n[0];
    assign stop_req  = ~sif.sync_n[1];
    assign smi_req   = ~sif.sync_n[2];

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        sgsc_pkg::sgsc_state_e state;               // Power state
        logic                  smi_prev;            // Edge detect on sync SMI
        logic                  smi_pend;            // Latched SMI awaiting entry
        logic                  core_clk_en;
        logic                  bus_clk_en;
        logic                  lic_clk_en;
        logic                  pll_en;
        logic                  snoop_en;
        logic                  intr_en;
        logic                  exec_en;
        logic                  state_save;
        logic                  system_management_mode;
        logic                  handler_start;
        logic                  ack_valid;
        logic [1:0]            ack_type;
        logic                  sleep;
    } sgsc_ctrl_s;

    sgsc_ctrl_s s_q;                                // Registered state
    sgsc_ctrl_s s_d;                                // Next state

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d               = s_q;
        s_d.state_save    = 1'b0;
        s_d.handler_start = 1'b0;
        s_d.smi_prev      = smi_req;

        // Drop acknowledge once the bus has taken it
        if (s_q.ack_valid && ack_done_i) begin
            s_d.ack_valid = 1'b0;
            s_d.ack_type  = sgsc_pkg::SGSC_ACK_NONE;
        end

        // Falling edge of SMI latches a request; the later clear in RUN beats the set
        if (smi_req && !s_q.smi_prev && s_q.state != sgsc_pkg::SGSC_SLEEP) begin
            s_d.smi_pend = 1'b1; // R11
        end

        case (s_q.state)
            sgsc_pkg::SGSC_RUN: begin
                if (s_q.smi_pend || (smi_req && !s_q.smi_prev)) begin
                    // Save state and enter management mode first
                    s_d.state      = sgsc_pkg::SGSC_SMM_ENT; // R12
                    s_d.smi_pend   = 1'b0;
                    s_d.state_save = 1'b1; // R12
                    s_d.system_management_mode        = 1'b1; // R12
                    s_d.exec_en    = 1'b0;
                end else if (stop_req && !s_d.ack_valid) begin
                    // Waits out a pending ack so its kind is never overwritten
                    s_d.state       = sgsc_pkg::SGSC_STPGNT; // R6
                    s_d.core_clk_en = 1'b0; // R6
                    s_d.exec_en     = 1'b0; // R6
                    s_d.ack_valid   = 1'b1; // R7
                    s_d.ack_type    = sgsc_pkg::SGSC_ACK_STPGNT; // R7
                end
            end
            sgsc_pkg::SGSC_STPGNT: begin
                // Bus and interrupt unit stay clocked; R8
                if (!stop_req) begin
                    s_d.state       = sgsc_pkg::SGSC_RUN; // R9
                    s_d.core_clk_en = 1'b1; // R9
                    s_d.exec_en     = 1'b1; // R9
                end else if (sleep_req) begin
                    s_d.state      = sgsc_pkg::SGSC_SLEEP; // R1
                    s_d.bus_clk_en = 1'b0; // R2
                    s_d.lic_clk_en = 1'b0; // R2
                    s_d.snoop_en   = 1'b0; // R3
                    s_d.intr_en    = 1'b0; // R3
                    s_d.sleep      = 1'b1;
                end
            end
            sgsc_pkg::SGSC_SLEEP: begin
                // Only sleep release moves us; snoops, interrupts, SMI ignored. R4
                if (!sleep_req) begin
                    s_d.state      = sgsc_pkg::SGSC_STPGNT; // R5
                    s_d.bus_clk_en = 1'b1; // R5
                    s_d.lic_clk_en = 1'b1; // R5
                    s_d.snoop_en   = 1'b1; // R5
                    s_d.intr_en    = 1'b1; // R5
                    s_d.sleep      = 1'b0;
                end
            end
            sgsc_pkg::SGSC_SMM_ENT: begin
                // Ack queued once the previous one has drained
                if (!s_d.ack_valid) begin
                    s_d.ack_valid     = 1'b1; // R13
                    s_d.ack_type      = sgsc_pkg::SGSC_ACK_SMI; // R13
                    s_d.state         = sgsc_pkg::SGSC_SMM;
                    s_d.handler_start = 1'b1; // R13
                    s_d.exec_en       = 1'b1; // R13
                end
            end
            sgsc_pkg::SGSC_SMM: begin
                // Handler runs until resume
                if (smm_resume_i) begin
                    s_d.state = sgsc_pkg::SGSC_RUN;
                    s_d.system_management_mode   = 1'b0;
                end
            end
            default: begin
                s_d.state = sgsc_pkg::SGSC_RUN;
            end
        endcase
        // Sleep request outside Stop-Grant simply never matches above; R14
    end

    // ------------------------------------------------------------
    // State register, reset to running with all clocks on
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q               <= '0;
            s_q.state         <= sgsc_pkg::SGSC_RUN;
            s_q.core_clk_en   <= 1'b1;
            s_q.bus_clk_en    <= 1'b1;
            s_q.lic_clk_en    <= 1'b1;
            s_q.pll_en        <= 1'b1; // R2
            s_q.snoop_en      <= 1'b1;
            s_q.intr_en       <= 1'b1;
            s_q.exec_en       <= 1'b1;
            s_q.ack_type      <= sgsc_pkg::SGSC_ACK_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign core_clk_en_o            = s_q.core_clk_en;
    assign bus_clk_en_o             = s_q.bus_clk_en;
    assign lic_clk_en_o             = s_q.lic_clk_en;
    assign pll_en_o                 = s_q.pll_en;
    assign snoop_en_o               = s_q.snoop_en;
    assign intr_en_o                = s_q.intr_en;
    assign exec_en_o                = s_q.exec_en;
    assign state_save_o             = s_q.state_save;
    assign system_management_mode_o = s_q.system_management_mode;
    assign handler_start_o          = s_q.handler_start;
    assign ack_valid_o              = s_q.ack_valid;
    assign ack_type_o               = s_q.ack_type;
    assign sleep_o                  = s_q.sleep;

    // Snoop and interrupt requests are gated by the enables downstream
    logic unused_req;
    assign unused_req = snoop_req_i ^ intr_req_i;

endmodule // sgsc_ctrl

// *** tb/sgsc_ctrl_asserts.sv ***
// ------------------------------------------------------------
// Port-level checks of the power-state controller
// ------------------------------------------------------------
module sgsc_ctrl_asserts (
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input wire logic       sleep_request_n_i,
    input wire logic       stop_clock_request_n_i,
    input wire logic       sys_mgmt_interrupt_n_i,
    input wire logic       snoop_req_i,
    input wire logic       intr_req_i,
    input wire logic       smm_resume_i,
    input wire logic       ack_done_i,
    input wire logic       core_clk_en_o,
    input wire logic       bus_clk_en_o,
    input wire logic       lic_clk_en_o,
    input wire logic       pll_en_o,
    input wire logic       snoop_en_o,
    input wire logic       intr_en_o,
    input wire logic       exec_en_o,
    input wire logic       state_save_o,
    input wire logic       handler_start_o,
    input wire logic       system_management_mode_o,
    input wire logic       ack_valid_o,
    input wire logic       sleep_o,
    input wire logic [1:0] ack_type_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_sleep_gates_clocks: assert property (sleep_o |->
        !core_clk_en_o && !bus_clk_en_o && !lic_clk_en_o && pll_en_o)
        else $error("clock enables wrong in sleep");
    a_sleep_no_snoop: assert property (sleep_o |-> !snoop_en_o && !intr_en_o)
        else $error("snoop or interrupt alive in sleep");
    // Sleep may only follow three edges of a held request from Stop-Grant
    a_sleep_entry_cause: assert property ($rose(sleep_o) |->
        !sleep_request_n_i && $past(!sleep_request_n_i, 2) && $past(!core_clk_en_o))
        else $error("sleep entered without request in stop grant");
    a_sleep_exit_path: assert property (sleep_o && $rose(sleep_request_n_i) |->
        ##3 !sleep_o && bus_clk_en_o && lic_clk_en_o)
        else $error("sleep release did not restart bus clocks");
    a_grant_ack_gating: assert property ($rose(ack_valid_o) &&
        ack_type_o == sgsc_pkg::SGSC_ACK_STPGNT |-> !core_clk_en_o && bus_clk_en_o && lic_clk_en_o)
        else $error("stop grant ack with wrong gating");
    a_grant_keeps_snoop: assert property (!core_clk_en_o && !sleep_o &&
        !system_management_mode_o |-> snoop_en_o && intr_en_o)
        else $error("stop grant lost snoop or interrupt");
    a_bus_clk_kept: assert property (!sleep_o |-> bus_clk_en_o)
        else $error("bus clock stopped outside sleep");
    a_stop_release: assert property ($rose(stop_clock_request_n_i) && !core_clk_en_o &&
        !sleep_o && !system_management_mode_o |-> ##3 core_clk_en_o && exec_en_o)
        else $error("stop release did not resume");
    a_smi_entry: assert property ($fell(sys_mgmt_interrupt_n_i) && exec_en_o &&
        !system_management_mode_o && core_clk_en_o |-> ##3 state_save_o && system_management_mode_o)
        else $error("management interrupt not taken in time");
    a_smi_ack_first: assert property (handler_start_o |-> ack_valid_o &&
        ack_type_o == sgsc_pkg::SGSC_ACK_SMI && $past(system_management_mode_o))
        else $error("handler started without management ack");
endmodule // sgsc_ctrl_asserts

bind sgsc_ctrl sgsc_ctrl_asserts chk_u (.*);

// *** tb/sgsc_chipset.sv ***
// ------------------------------------------------------------
// Chipset model: takes acknowledge transactions off the bus
// ------------------------------------------------------------
module sgsc_chipset (
    input  wire logic       clk_i,       // Bus clock
    input  wire logic       arst_n_i,    // Async reset, active low
    input  wire logic       ack_valid_i, // Ack transaction pending
    input  wire logic [3:0] delay_i,     // Stall cycles before taking it
    output logic            ack_done_o   // One-cycle take strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_q; // Cycles the ack has waited

    // Stall lets a pending ack overlap later state changes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q     <= 4'h0;
            ack_done_o <= 1'h0;
        end else if (ack_valid_i && !ack_done_o) begin
            ack_done_o <= (wait_q == delay_i);
            wait_q     <= wait_q + 4'h1;
        end else begin
            ack_done_o <= 1'h0;
            wait_q     <= 4'h0;
        end
    end
endmodule // sgsc_chipset

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Stimulus and observed outputs
    // ------------------------------------------------------------
    logic clk_i = 1'h0, arst_n_i = 1'h0, sleep_request_n_i = 1'h1, stop_clock_request_n_i = 1'h1;
    logic sys_mgmt_interrupt_n_i = 1'h1, snoop_req_i = 1'h1, intr_req_i = 1'h1, smm_resume_i = 1'h0;
    logic ack_done_i, core_clk_en_o, bus_clk_en_o, lic_clk_en_o, pll_en_o, snoop_en_o, intr_en_o;
    logic exec_en_o, state_save_o, system_management_mode_o, handler_start_o, ack_valid_o, sleep_o;
    logic [1:0] ack_type_o;
    logic [3:0] delay_q = 4'h4; // Chipset stall
    int         error_cnt = 0;
    int         checked = 0;

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end

    always #12.5 clk_i = ~clk_i; // 40 MHz bus clock

    sgsc_ctrl dut_u (.*);
    sgsc_chipset partner_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ack_valid_i(ack_valid_o),
        .delay_i(delay_q), .ack_done_o(ack_done_i));

    // Let n edges pass, then look once outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic end_of_test;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Sleep asked from RUN must be ignored
    task automatic t_sleep_outside;
        @(posedge clk_i) sleep_request_n_i <= 1'h0;
        step(4);
        `CHK("sleep_o", 1'h0, sleep_o)
        `CHK("core_clk_en_o", 1'h1, core_clk_en_o)
        @(posedge clk_i) sleep_request_n_i <= 1'h1;
        step(3);
    endtask

    // Stop-Grant, Sleep with an ignored interrupt, and back out
    task automatic t_stop_sleep;
        @(posedge clk_i) stop_clock_request_n_i <= 1'h0;
        step(3);
        `CHK("core_clk_en_o", 1'h0, core_clk_en_o)
        `CHK("exec_en_o", 1'h0, exec_en_o)
        `CHK("lic_clk_en_o", 1'h1, lic_clk_en_o)
        `CHK("bus_clk_en_o", 1'h1, bus_clk_en_o)
        `CHK("ack_valid_o", 1'h1, ack_valid_o)
        `CHK("ack_type_o", sgsc_pkg::SGSC_ACK_STPGNT, ack_type_o)
        `CHK("snoop_en_o", 1'h1, snoop_en_o)
        `CHK("intr_en_o", 1'h1, intr_en_o)
        @(posedge clk_i) sleep_request_n_i <= 1'h0;
        step(3);
        `CHK("sleep_o", 1'h1, sleep_o)
        `CHK("bus_clk_en_o", 1'h0, bus_clk_en_o)
        `CHK("pll_en_o", 1'h1, pll_en_o)
        `CHK("snoop_en_o", 1'h0, snoop_en_o)
        @(posedge clk_i) sys_mgmt_interrupt_n_i <= 1'h0;
        step(4);
        `CHK("system_management_mode_o", 1'h0, system_management_mode_o)
        `CHK("sleep_o", 1'h1, sleep_o)
        @(posedge clk_i) sleep_request_n_i <= 1'h1;
        sys_mgmt_interrupt_n_i <= 1'h1;
        step(3);
        `CHK("sleep_o", 1'h0, sleep_o)
        `CHK("lic_clk_en_o", 1'h1, lic_clk_en_o)
        `CHK("core_clk_en_o", 1'h0, core_clk_en_o)
        @(posedge clk_i) stop_clock_request_n_i <= 1'h1;
        step(3);
        `CHK("core_clk_en_o", 1'h1, core_clk_en_o)
        `CHK("exec_en_o", 1'h1, exec_en_o)
        `CHK("ack_valid_o", 1'h0, ack_valid_o)
        `CHK("system_management_mode_o", 1'h0, system_management_mode_o)
    endtask

    // Management interrupt with a prompt chipset
    task automatic t_smi;
        delay_q <= 4'h0;
        @(posedge clk_i) sys_mgmt_interrupt_n_i <= 1'h0;
        step(3);
        `CHK("state_save_o", 1'h1, state_save_o)
        `CHK("system_management_mode_o", 1'h1, system_management_mode_o)
        step(1);
        `CHK("state_save_o", 1'h0, state_save_o)
        `CHK("handler_start_o", 1'h1, handler_start_o)
        `CHK("ack_type_o", sgsc_pkg::SGSC_ACK_SMI, ack_type_o)
        `CHK("exec_en_o", 1'h1, exec_en_o)
        @(posedge clk_i) sys_mgmt_interrupt_n_i <= 1'h1;
        smm_resume_i <= 1'h1;
        @(posedge clk_i) smm_resume_i <= 1'h0;
        step(2);
        `CHK("system_management_mode_o", 1'h0, system_management_mode_o)
    endtask

    // Management interrupt in Stop-Grant waits for the return to running
    task automatic t_smi_in_grant;
        @(posedge clk_i) stop_clock_request_n_i <= 1'h0;
        step(3);
        `CHK("exec_en_o", 1'h0, exec_en_o)
        @(posedge clk_i) sys_mgmt_interrupt_n_i <= 1'h0;
        step(4);
        `CHK("system_management_mode_o", 1'h0, system_management_mode_o)
        `CHK("snoop_en_o", 1'h1, snoop_en_o)
        @(posedge clk_i) stop_clock_request_n_i <= 1'h1;
        step(3);
        `CHK("core_clk_en_o", 1'h1, core_clk_en_o)
        step(1);
        `CHK("state_save_o", 1'h1, state_save_o)
        `CHK("system_management_mode_o", 1'h1, system_management_mode_o)
        @(posedge clk_i) sys_mgmt_interrupt_n_i <= 1'h1;
        smm_resume_i <= 1'h1;
        @(posedge clk_i) smm_resume_i <= 1'h0;
        step(2);
        `CHK("system_management_mode_o", 1'h0, system_management_mode_o)
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        step(15);
        `CHK("pll_en_o", 1'h1, pll_en_o)
        `CHK("ack_valid_o", 1'h0, ack_valid_o)
        @(posedge clk_i) arst_n_i <= 1'h1;
        step(2);
        t_sleep_outside();
        t_stop_sleep();
        t_smi();
        t_smi_in_grant();
        end_of_test();
    end

    // Whole run is about 80 cycles; this is far beyond it
    initial begin
        #50us;
        error_cnt++;
        end_of_test();
    end
endmodule // testbench
